/* design/arc_refresh_ctrl.sv */
// Area-3 refresh controller: timer, refresh sequencer and DRAM strobe generation.
`timescale 1ns/1ps
`include "arc_consts.svh"
// Functional notes
// - No memory enables: plain interval timer.
// - Timer mode match raises interrupt when enabled.
// - Memory enabled locks constant, counter, clock select and control bits 4:2, 0.
// - Interval is constant times prescaler tap.
// - Refresh waits for bus grant.
// - Cycles take three states, waits optional.
// - Refresh only with cycle and memory enable.
// - First request after reset only pends.
// - Pending request acquires bus, refreshes once.
// - Request during refresh cycle is dropped.
// - Multiplexing applies to area three only.
// - Column phase remaps upper address bits.
// - Strobe mode picks two-CAS or two-WE.
// - Pin enable gates dedicated refresh strobe, except in self-refresh.
// - Match sets flag and clears counter.
// - Interrupt enable forced low with memory.
// - Write, read pins map to DRAM strobes.
// - Self-refresh in standby: CAS then RAS low.
module arc_refresh_ctrl
   import arc_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Standby entry, from the power controller.
   input  wire logic        swStandby,
   // Software register writes, one-cycle strobes.
   input  wire logic        ctrlWrite,
   input  wire logic        tmcsWrite,
   input  wire logic        constWrite,
   input  wire logic        cntWrite,
   input  wire logic [7:0]  writeData,
   input  wire logic        flagReadArm,
   // Bus arbiter.
   input  wire logic        busGrant,
   // CPU access to external space.
   input  wire logic        accessActive,
   input  wire logic        accessWrite,
   input  wire logic        accessUpper,
   input  wire logic        accessLower,
   input  wire logic        columnPhase,
   input  wire logic [23:0] accessAddr,
   input  wire logic        area3_access_state_bit,
   input  wire logic        waitIn,
   // Register readback.
   output logic [7:0]       refresh_control_reg,
   output logic [7:0]       refresh_timer_ctrl_status,
   output logic [7:0]       refresh_time_constant,
   output logic [7:0]       refresh_timer_counter,
   // Arbiter and interrupt.
   output logic             busRequest,
   output logic             compare_match_interrupt,
   // Memory pins, active low strobes; refreshActive is an active-high status.
   output logic [23:0]      addrPin,
   output logic             rowStrobe_n,
   output logic             high_write_pin_n,
   output logic             low_write_pin_n,
   output logic             readPin_n,
   output logic             refresh_strobe_pin_n,
   output logic             refreshActive
);
   logic             psramEn, dramEn, memEn, compare_match_flag, compare_match_irq_enable;
   logic [2:0]       cks;
   logic [`ARC_PRESCALE_W-1:0] prescale;
   logic             tick, match, firstSeen;
   logic [1:0]       stateCnt;
   logic             standbyS1, standbyS2;
   logic [23:0]      next_addr;
   arc_state_e       state;

   assign psramEn = refresh_control_reg[`ARC_CTRL_PSEUDO_STATIC_ENABLE];
   assign dramEn  = refresh_control_reg[`ARC_CTRL_DYNAMIC_RAM_ENABLE];
   assign memEn   = psramEn | dramEn;
   assign compare_match_flag     = refresh_timer_ctrl_status[7];
   assign compare_match_irq_enable    = refresh_timer_ctrl_status[6];
   assign cks     = refresh_timer_ctrl_status[5:3];
   assign match   = refresh_timer_counter == refresh_time_constant;

   // Standby level from another domain passes two flops.
   always_ff @(posedge ref_clk) begin
      standbyS1 <= swStandby;
      standbyS2 <= standbyS1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || standbyS2)
         prescale <= '0;
      else
         prescale <= prescale + 1'b1;
   end
   always_comb begin
      case (cks)
         3'h1:    tick = prescale[0:0] == 1'h1;
         3'h2:    tick = prescale[2:0] == 3'h7;
         3'h3:    tick = prescale[4:0] == 5'h1f;
         3'h4:    tick = prescale[6:0] == 7'h7f;
         3'h5:    tick = prescale[8:0] == 9'h1ff;
         3'h6:    tick = prescale[10:0] == 11'h7ff;
         3'h7:    tick = prescale == 12'hfff;
         default: tick = 1'b0;
      endcase
   end

   // Control register; bits 4:2 and 0 write-locked while memory is enabled.
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         refresh_control_reg <= `ARC_CTRL_RESET;
      else if (ctrlWrite) begin
         refresh_control_reg[7:5] <= writeData[7:5];
         if (!memEn) begin
            refresh_control_reg[4:2] <= writeData[4:2];
            refresh_control_reg[0]   <= writeData[0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         refresh_time_constant <= `ARC_TCONST_RESET;
      else if (constWrite && !memEn)
         refresh_time_constant <= writeData;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || standbyS2)
         refresh_timer_counter <= `ARC_CNT_RESET;
      else if (cntWrite && !memEn)
         refresh_timer_counter <= writeData;
      else if (match)
         refresh_timer_counter <= `ARC_CNT_RESET;
      else if (tick)
         refresh_timer_counter <= refresh_timer_counter + 8'h01;
   end

   // Status register: flag set wins over the zero-write clear.
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         refresh_timer_ctrl_status <= `ARC_TMCS_RESET;
      else begin
         if (standbyS2)
            refresh_timer_ctrl_status[7:6] <= 2'h0;
         else begin
            if (match)
               refresh_timer_ctrl_status[7] <= 1'b1;
            else if (tmcsWrite && flagReadArm && !writeData[7])
               refresh_timer_ctrl_status[7] <= 1'b0;
            if (memEn)
               refresh_timer_ctrl_status[6] <= 1'b0;
            else if (tmcsWrite)
               refresh_timer_ctrl_status[6] <= writeData[6];
         end
         if (tmcsWrite && !memEn)
            refresh_timer_ctrl_status[5:3] <= writeData[5:3];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         compare_match_interrupt <= 1'b0;
      else
         compare_match_interrupt <= compare_match_flag & compare_match_irq_enable & !memEn;
   end

   // first request only arms pending; enables gate it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n || standbyS2)
         firstSeen <= 1'b0;
      else if (match && memEn && refresh_control_reg[`ARC_CTRL_REFRESH_CYCLE_ENABLE])
         firstSeen <= 1'b1;
   end

   // Refresh sequencer.
   always_ff @(posedge ref_clk) begin
      if (!rst_n || standbyS2) begin
         state    <= ARC_IDLE;
         stateCnt <= 2'h0;
      end else begin
         case (state)
            ARC_IDLE: begin
               if (firstSeen)
                  state <= ARC_PENDING;
            end
            ARC_PENDING: begin
               if (match && memEn && refresh_control_reg[`ARC_CTRL_REFRESH_CYCLE_ENABLE])
                  state <= ARC_REQUEST;
            end
            ARC_REQUEST: begin
               if (busGrant) begin
                  state    <= ARC_CYCLE;
                  stateCnt <= 2'h1;
               end
            end
            ARC_CYCLE: begin
               // three states, matches here are dropped
               if (stateCnt == `ARC_CYCLE_STATES &&
                   !(area3_access_state_bit && waitIn))
                  state <= ARC_PENDING;
               else if (stateCnt != `ARC_CYCLE_STATES)
                  stateCnt <= stateCnt + 2'h1;
            end
            default: state <= ARC_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         busRequest <= 1'b0;
      else
         busRequest <= (state == ARC_REQUEST) && !busGrant && !standbyS2;
   end

   arc_addr_mux u_mux (
      .addrIn              (accessAddr),
      .area3Sel            (dramEn && accessActive),
      .columnPhase         (columnPhase),
      .column_width_select (refresh_control_reg[`ARC_CTRL_COLW]),
      .addrOut             (next_addr)
   );

   // Address pins registered.
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         addrPin <= 24'h000000;
      else
         addrPin <= next_addr;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rowStrobe_n          <= 1'b1;
         high_write_pin_n     <= 1'b1;
         low_write_pin_n      <= 1'b1;
         readPin_n            <= 1'b1;
         refresh_strobe_pin_n <= 1'b1;
         refreshActive        <= 1'b0;
      end else if (standbyS2 && dramEn && refresh_control_reg[`ARC_CTRL_SELF_REFRESH_SELECT]) begin
         readPin_n            <= refresh_control_reg[`ARC_CTRL_CASWE];
         high_write_pin_n     <= !refresh_control_reg[`ARC_CTRL_CASWE];
         low_write_pin_n      <= !refresh_control_reg[`ARC_CTRL_CASWE];
         rowStrobe_n          <= (refresh_control_reg[`ARC_CTRL_CASWE] ? !high_write_pin_n
                                                                        : !readPin_n) ? 1'b0
                                                                                      : 1'b1;
         refresh_strobe_pin_n <= 1'b0;
         refreshActive        <= 1'b0;
      end else begin
         refreshActive        <= state == ARC_CYCLE;
         refresh_strobe_pin_n <= !(state == ARC_CYCLE && refresh_control_reg[`ARC_CTRL_REFRESH_PIN_ENABLE]);
         rowStrobe_n          <= !(dramEn && accessActive);
         if (refresh_control_reg[`ARC_CTRL_CASWE]) begin
            high_write_pin_n <= !(state == ARC_CYCLE || (accessActive && accessUpper));
            low_write_pin_n  <= !(state == ARC_CYCLE || (accessActive && accessLower));
            readPin_n        <= !(accessActive && accessWrite);
         end else begin
            high_write_pin_n <= !(accessActive && accessWrite && accessUpper);
            low_write_pin_n  <= !(accessActive && accessWrite && accessLower);
            readPin_n        <= !(state == ARC_CYCLE || (accessActive && columnPhase));
         end
      end
   end
endmodule

/* design/arc_consts.svh */
// Constants for the area-3 refresh controller: field positions, reset values and counts.
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH
`define ARC_CTRL_SELF_REFRESH_SELECT   7
`define ARC_CTRL_PSEUDO_STATIC_ENABLE  6
`define ARC_CTRL_DYNAMIC_RAM_ENABLE   5
`define ARC_CTRL_CASWE   4
`define ARC_CTRL_COLW    3
`define ARC_CTRL_REFRESH_PIN_ENABLE   2
`define ARC_CTRL_RSV1    1
`define ARC_CTRL_REFRESH_CYCLE_ENABLE   0
`define ARC_CTRL_RESET   8'h02
`define ARC_TMCS_RESET   8'h07
`define ARC_TCONST_RESET 8'hff
`define ARC_CNT_RESET    8'h00
`define ARC_CYCLE_STATES 2'h3
`define ARC_PRESCALE_W   12
`endif

/* design/arc_pkg.sv */
// Types shared by the area-3 refresh controller files.
package arc_pkg;
   typedef enum logic [3:0] {
      ARC_IDLE    = 4'b0001,
      ARC_PENDING = 4'b0010,
      ARC_REQUEST = 4'b0100,
      ARC_CYCLE   = 4'b1000
   } arc_state_e;
   typedef logic [7:0] arc_byte_t;
endpackage

/* design/arc_addr_mux.sv */
// Row and column address multiplexer for area-3 accesses.
`timescale 1ns/1ps
`include "arc_consts.svh"
module arc_addr_mux
   import arc_pkg::*;
(
   // Request address and phase.
   input  wire logic [23:0] addrIn,
   input  wire logic        area3Sel,
   input  wire logic        columnPhase,
   input  wire logic        column_width_select,
   // Pin address.
   output logic [23:0]      addrOut
);
   always_comb begin
      addrOut = addrIn;
      if (area3Sel && columnPhase) begin
         addrOut[7:1] = addrIn[16:10];
         addrOut[9]   = column_width_select ? addrIn[18] : addrIn[9];
         addrOut[8]   = column_width_select ? addrIn[17] : addrIn[9];
      end
   end
endmodule

/* testbench/arc_refresh_props.sv */
// Port assertions for the area-3 refresh controller.
`timescale 1ns/1ps
module arc_refresh_props (
   // Clock, reset and watched inputs.
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       busGrant,
   input wire logic       constWrite,
   input wire logic       area3_access_state_bit,
   // Watched outputs.
   input wire logic [7:0] refresh_control_reg,
   input wire logic [7:0] refresh_timer_ctrl_status,
   input wire logic [7:0] refresh_time_constant,
   input wire logic [7:0] refresh_timer_counter,
   input wire logic       busRequest,
   input wire logic       compare_match_interrupt,
   input wire logic       refresh_strobe_pin_n,
   input wire logic       refreshActive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // High while a memory type is enabled.
   wire logic memOn = |refresh_control_reg[6:5];
   // A refresh cycle holds three states, then ends.
   sequence s_cycle;
      refreshActive [*3] ##1 !refreshActive;
   endsequence
   AST_TIMER_NO_CYCLE: assert property (!memOn |-> !refreshActive)
      else $error("refresh cycle in timer mode");
   AST_IRQ_FROM_FLAG: assert property (compare_match_interrupt ==
      $past(refresh_timer_ctrl_status[7] & refresh_timer_ctrl_status[6]))
      else $error("interrupt does not follow flag and enable");
   AST_CONST_LOCKED: assert property (memOn && constWrite |=> $stable(refresh_time_constant))
      else $error("locked constant changed");
   AST_CYCLE_THREE: assert property ($rose(refreshActive) && !area3_access_state_bit |-> s_cycle)
      else $error("refresh cycle length wrong");
   AST_GRANT_FIRST: assert property ($rose(refreshActive) |-> $past(busGrant, 2) || $past(busGrant, 3))
      else $error("refresh cycle without grant");
   AST_PIN_GATE: assert property (refreshActive |-> refresh_strobe_pin_n == !refresh_control_reg[2])
      else $error("refresh strobe level wrong");
   AST_MATCH_CLEARS: assert property (refresh_timer_counter == refresh_time_constant && !constWrite
      |=> refresh_timer_ctrl_status[7] && refresh_timer_counter == 8'h00)
      else $error("match did not set flag and clear counter");
   AST_IRQEN_FORCED: assert property (memOn [*2] |-> !refresh_timer_ctrl_status[6])
      else $error("interrupt enable set with memory on");
   AST_REQ_HELD: assert property (busRequest && !busGrant |=> busRequest)
      else $error("request dropped before grant");
endmodule
bind arc_refresh_ctrl arc_refresh_props i_props (.ref_clk, .rst_n, .busGrant, .constWrite,
   .area3_access_state_bit, .refresh_control_reg, .refresh_timer_ctrl_status,
   .refresh_time_constant, .refresh_timer_counter, .busRequest, .compare_match_interrupt,
   .refresh_strobe_pin_n, .refreshActive);

/* testbench/arc_dram_model.sv */
// Behavioural memory chip on area 3 that counts dedicated refresh strobes.
`timescale 1ns/1ps
module arc_dram_model (
   // Strobes from the controller.
   input  wire logic rowStrobe_n,
   input  wire logic refresh_strobe_pin_n,
   // Refreshes seen.
   output int        refreshSeen
);
   initial refreshSeen = 0;
   always @(negedge refresh_strobe_pin_n) refreshSeen++;
endmodule

/* testbench/tb_arc_refresh_ctrl.sv */
// Self-checking bench for the area-3 refresh controller.
`timescale 1ns/1ps
module tb_arc_refresh_ctrl;
   logic        ref_clk = 0, rst_n = 0, ctrlWrite = 0, tmcsWrite = 0, constWrite = 0;
   logic        flagReadArm = 0, busGrant = 0, accessActive = 0, columnPhase = 0;
   logic        accessUpper = 0, accessLower = 0, raD = 0, irqD = 0, accessWrite = 0;
   logic [7:0]  writeData = 0, k, expQ[$];
   logic [23:0] accessAddr = 0, a;
   wire  [7:0]  refresh_control_reg, refresh_timer_ctrl_status, refresh_time_constant;
   wire  [7:0]  refresh_timer_counter;
   wire  [23:0] addrPin;
   wire         busRequest, compare_match_interrupt, rowStrobe_n, refresh_strobe_pin_n;
   wire         refreshActive;
   int          fails = 0, num_checks = 0, cyc = 0, seen, nRef = 0, s0;
   bit          grantOn = 0, granting = 0, pinEn = 0;
   longint      t0;
   always #10 ref_clk = ~ref_clk;
   arc_refresh_ctrl i_dut (.ref_clk, .rst_n, .swStandby(1'b0), .ctrlWrite, .tmcsWrite,
      .constWrite, .cntWrite(1'b0), .writeData, .flagReadArm, .busGrant, .accessActive,
      .accessWrite, .accessUpper, .accessLower, .columnPhase, .accessAddr,
      .area3_access_state_bit(1'b0), .waitIn(1'b0), .refresh_control_reg,
      .refresh_timer_ctrl_status, .refresh_time_constant, .refresh_timer_counter,
      .busRequest, .compare_match_interrupt, .addrPin, .rowStrobe_n, .high_write_pin_n(),
      .low_write_pin_n(), .readPin_n(), .refresh_strobe_pin_n, .refreshActive);
   arc_dram_model i_mem (.rowStrobe_n, .refresh_strobe_pin_n, .refreshSeen(seen));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One-cycle register write: 0 control, 1 timer control, 2 constant.
   task automatic wr(input int which, input logic [7:0] d);
      @(posedge ref_clk);
      writeData <= d;
      ctrlWrite <= (which == 0);
      tmcsWrite <= (which == 1);
      constWrite <= (which == 2);
      @(posedge ref_clk);
      {ctrlWrite, tmcsWrite, constWrite} <= 3'h0;
   endtask
   task automatic waitCnt(input logic [7:0] v);
      for (int i = 0; i < 300 && refresh_timer_counter !== v; i++) @(posedge ref_clk);
   endtask
   task automatic muxCase(input logic [23:0] ad, input logic col, input logic [23:0] exp);
      @(posedge ref_clk);
      accessAddr <= ad;
      columnPhase <= col;
      repeat (2) @(posedge ref_clk);
      #1 chk(addrPin, exp);
   endtask
   // Hang guard; the run needs well under this many cycles.
   always @(posedge ref_clk) if (++cyc > 6000) begin
      fails++;
      print_verdict();
   end
   // Compares each new event with the oldest note.
   always @(posedge ref_clk) begin
      raD <= refreshActive;
      irqD <= compare_match_interrupt;
      if (refreshActive && !raD) begin
         nRef++;
         chk(8'h20 | 8'(refresh_strobe_pin_n), expQ.size() ? expQ.pop_front() : 8'hee);
      end
      if (compare_match_interrupt && !irqD)
         chk(8'h10, expQ.size() ? expQ.pop_front() : 8'hee);
   end
   // Arbiter stand-in: grants after a random delay, holds until the request drops.
   always @(posedge ref_clk) if (grantOn && busRequest && !busGrant) begin
      granting = 1;
      repeat ($urandom_range(8, 0)) @(posedge ref_clk);
      expQ.push_back({7'h10, !pinEn});
      busGrant <= 1;
      while (busRequest) @(posedge ref_clk);
      busGrant <= 0;
      granting = 0;
   end
   initial begin
      void'($urandom(32'h742c));
      repeat (8) @(posedge ref_clk);
      rst_n <= 1;
      #1 chk(refresh_control_reg, 8'h02);
      chk(refresh_timer_ctrl_status, 8'h07);
      chk(refresh_time_constant, 8'hff);
      chk(refresh_timer_counter, 8'h00);
      $display("test reset done");
      k = 8'($urandom_range(6, 2));
      wr(2, k);
      wr(1, 8'h08);
      wr(1, 8'h48);
      expQ.push_back(8'h10);
      waitCnt(k);
      t0 = $time;
      @(posedge ref_clk);
      waitCnt(k);
      chk(24'(($time - t0) / 20), 24'(2 * k));
      flagReadArm <= 1;
      wr(1, 8'h08);
      repeat (2) @(posedge ref_clk);
      #1 chk(compare_match_interrupt, 1'b0);
      $display("test timer done");
      rst_n <= 0;
      flagReadArm <= 0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1;
      wr(2, 8'h08);
      wr(1, 8'h08);
      wr(0, 8'h25);
      pinEn = 1;
      waitCnt(8'h08);
      repeat (8) @(posedge ref_clk);
      chk(busRequest, 1'b0);
      wr(2, 8'h55);
      #1 chk(refresh_time_constant, 8'h08);
      for (int i = 0; i < 40 && !busRequest; i++) @(posedge ref_clk);
      chk(busRequest, 1'b1);
      a = {8'h66, 16'($urandom)};
      accessActive <= 1;
      accessWrite <= 1'($urandom);
      accessUpper <= 1;
      accessLower <= 1;
      muxCase(a, 1'b0, a);
      muxCase(a, 1'b1, {a[23:10], a[9], a[9], a[16:10], a[0]});
      // Outside area three no access is active, so the address passes unmultiplexed.
      @(posedge ref_clk);
      accessActive <= 0;
      accessWrite <= 0;
      muxCase({8'h20, a[15:0]}, 1'b1, {8'h20, a[15:0]});
      $display("test address done");
      grantOn = 1;
      for (int i = 0; i < 600 && nRef < 3; i++) @(posedge ref_clk);
      #1 chk(nRef, 3);
      chk(seen, nRef);
      grantOn = 0;
      for (int i = 0; i < 40 && (granting || refreshActive); i++) @(posedge ref_clk);
      pinEn = 0;
      wr(0, 8'h00);
      wr(0, 8'h41);
      #1 chk(refresh_control_reg, 8'h43);
      s0 = seen;
      grantOn = 1;
      for (int i = 0; i < 600 && nRef < 5; i++) @(posedge ref_clk);
      #1 chk(seen, s0);
      chk(expQ.size(), 0);
      $display("test refresh done");
      print_verdict();
   end
endmodule
